// ==== pkg/scg_map.vh ====
`ifndef SCG_MAP_VH
`define SCG_MAP_VH
// Settling delay before the external input clock counts as confirmed
`define SCG_SETTLE_US 500
// Reference clock period
`define SCG_REF_PERIOD_NS 25
// Least settle count, rounded up to whole reference cycles
`define SCG_SETTLE_CYCLES ((`SCG_SETTLE_US * 1000 + `SCG_REF_PERIOD_NS - 1) / `SCG_REF_PERIOD_NS)
// Threshold for duty adjustment, in kHz
`define SCG_DUTY_THRESH_KHZ 5000
// Prescaler width: taps from /2 to /4096
`define SCG_PRESCALE_BITS 12
`endif

// ==== logic/scg_prescaler.v ====
`timescale 1ns/100ps
// Free-running divider; bit k toggles at peripheral rate / 2^(k+1)
module scg_prescaler #(
   parameter WIDTH = 12
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire clk_en,
   input wire tick,
   output reg [WIDTH-1:0] taps
);
   // Counter advances once per peripheral clock tick
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         taps <= {WIDTH{1'b0}};
      end else if (clk_en && tick) begin
         taps <= taps + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule

// ==== logic/scg_clock_gen.v ====
// Operation
// - Clock confirmed only after 500 us settle
// - Duty adjust used at 5 MHz and above
// - Peripheral clock is system clock or half
// - Prescaler taps span half to 1/4096
`timescale 1ns/100ps
`include "scg_map.vh"
module scg_clock_gen #(
   parameter SETTLE_CYCLES = `SCG_SETTLE_CYCLES,
   parameter PRESCALE_BITS = `SCG_PRESCALE_BITS,
   parameter DUTY_THRESH_KHZ = `SCG_DUTY_THRESH_KHZ
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire clk_en,
   input wire ext_clock_input_pin,
   input wire [15:0] ext_clock_khz,
   input wire clock_halve_select,
   output reg sys_clock,
   output reg clock_confirmed,
   output reg duty_adjust_active,
   output reg periph_tick,
   output wire [PRESCALE_BITS-1:0] prescale_taps
);
   reg ext_meta;
   reg ext_sync;
   reg ext_prev;
   reg ext_seen;
   reg [31:0] settle_count;
   reg half_phase;
   reg sys_edge;
   // Threshold cut to the width of the frequency port on purpose
   localparam [31:0] THRESH_FULL = DUTY_THRESH_KHZ;
   wire [15:0] thresh = THRESH_FULL[15:0];

   // Two-stage synchroniser; only ext_sync and ext_prev are read by logic
   // Reset high so a pin parked high gives no false first edge
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ext_meta <= 1'b1;
         ext_sync <= 1'b1;
         ext_prev <= 1'b1;
      end else if (clk_en) begin
         ext_meta <= ext_clock_input_pin;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end

   // Settle timer starts at first rising input edge; the partner keeps reset meanwhile
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ext_seen <= 1'b0;
         settle_count <= 32'h00000000;
         clock_confirmed <= 1'b0;
      end else if (clk_en) begin
         if (ext_sync && !ext_prev) begin
            ext_seen <= 1'b1;
         end
         if (ext_seen && !clock_confirmed) begin
            if (settle_count >= SETTLE_CYCLES - 1) begin
               clock_confirmed <= 1'b1;
            end else begin
               settle_count <= settle_count + 32'h00000001;
            end
         end
      end
   end

   // System clock: rebuilt from input edges when fast, raw otherwise; gated until confirmed
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         duty_adjust_active <= 1'b0;
         sys_clock <= 1'b0;
         sys_edge <= 1'b0;
      end else if (clk_en) begin
         duty_adjust_active <= (ext_clock_khz >= thresh);
         sys_edge <= clock_confirmed && ext_sync && !ext_prev;
         if (!clock_confirmed) begin
            sys_clock <= 1'b0;
         end else if (duty_adjust_active) begin
            // Rebuild from both rising and falling edges, so input duty skew is kept
            if (ext_sync && !ext_prev) begin
               sys_clock <= 1'b1;
            end else if (!ext_sync && ext_prev) begin
               sys_clock <= 1'b0;
            end
         end else begin
            sys_clock <= ext_sync;
         end
      end
   end

   // Peripheral tick: every system edge, or every other one when halved
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         half_phase <= 1'b0;
         periph_tick <= 1'b0;
      end else if (clk_en) begin
         periph_tick <= 1'b0;
         if (sys_edge) begin
            half_phase <= ~half_phase;
            periph_tick <= clock_halve_select ? half_phase : 1'b1;
         end
      end
   end

   scg_prescaler #(
      .WIDTH(PRESCALE_BITS)
   ) u_prescaler (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .tick(periph_tick),
      .taps(prescale_taps)
   );
endmodule

// ==== testbench/scg_ext_src.sv ====
`timescale 1ns/100ps
// Clock source; parked high while stopped
module scg_ext_src(
   input wire ref_clk,
   input wire run,
   output reg pin = 1'b1
);
   reg [1:0] cnt = 2'h0;
   // Eight-cycle period, equal to the wanted clock
   always @(posedge ref_clk) begin
      cnt <= cnt + 2'h1;
      if (!run) pin <= 1'b1;
      else if (cnt == 2'h3) pin <= ~pin;
   end
endmodule

// ==== testbench/scg_chk.sv ====
`timescale 1ns/100ps
module scg_chk #(parameter PRESCALE_BITS = 12) (
   input wire ref_clk,
   input wire sys_rst,
   input wire clk_en,
   input wire [15:0] ext_clock_khz,
   input wire clock_halve_select,
   input wire sys_clock,
   input wire clock_confirmed,
   input wire duty_adjust_active,
   input wire periph_tick,
   input wire [PRESCALE_BITS-1:0] prescale_taps
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   a_gate_early: assert property (!clock_confirmed |-> !sys_clock && !periph_tick) else $error("early");
   a_confirm_holds: assert property (clock_confirmed |=> clock_confirmed) else $error("lost");
   a_duty_thresh: assert property (clk_en |=> duty_adjust_active == ($past(ext_clock_khz) >= 16'h1388))
      else $error("duty");
   // The gap outlasts one eight-cycle input period
   a_halve_gap: assert property (clock_halve_select && periph_tick |=> !periph_tick [*8]) else $error("half");
   a_tap_step: assert property (clk_en && periph_tick |=> prescale_taps == $past(prescale_taps) + 1'b1)
      else $error("taps");
endmodule
bind scg_clock_gen scg_chk #(.PRESCALE_BITS(PRESCALE_BITS)) scg_chk_inst(.ref_clk(ref_clk), .sys_rst(sys_rst),
   .clk_en(clk_en), .ext_clock_khz(ext_clock_khz), .clock_halve_select(clock_halve_select), .sys_clock(sys_clock),
   .clock_confirmed(clock_confirmed), .duty_adjust_active(duty_adjust_active), .periph_tick(periph_tick),
   .prescale_taps(prescale_taps));

// ==== testbench/system_clock_generator_tb_top.sv ====
`timescale 1ns/100ps
module system_clock_generator_tb_top;
   reg ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, run = 1'b0, sel = 1'b0;
   reg [15:0] khz = 16'h0000;
   reg [11:0] t0;
   wire pin, sclk, conf, duty, tick;
   wire [11:0] taps;
   integer failures = 0, n_compared = 0, i, n, m;
   always #12.5 ref_clk = ~ref_clk;
   scg_ext_src scg_ext_src_inst(.ref_clk(ref_clk), .run(run), .pin(pin));
   scg_clock_gen #(.SETTLE_CYCLES(8)) scg_clock_gen_inst(.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .ext_clock_input_pin(pin), .ext_clock_khz(khz), .clock_halve_select(sel), .sys_clock(sclk),
      .clock_confirmed(conf), .duty_adjust_active(duty), .periph_tick(tick), .prescale_taps(taps));
   task check(input [15:0] s, input [15:0] e);
      n_compared = n_compared + 1;
      if (s !== e) begin
         failures = failures + 1;
         $display("[ERR] %0t %h %h", $time, s, e);
      end
   endtask
   task final_report;
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Clock runs while reset is held, then settle is timed
   task t_ratio(input s, input [15:0] e);
      @(posedge ref_clk) sys_rst <= 1'b1;
      sel <= s;
      run <= 1'b1;
      repeat (2) @(posedge ref_clk) sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 check(conf, 16'h0000);
      i = 0;
      while (tick !== 1'b1 && i < 60) begin
         @(posedge ref_clk) #1 i = i + 1;
      end
      check(conf, 16'h0001);
      t0 = taps;
      n = 0;
      m = 0;
      // System clock high half of the time: same duty as the source
      repeat (128) @(posedge ref_clk) begin
         #1 n = n + tick;
         m = m + sclk;
      end
      check(n[15:0], e);
      check(m[15:0], 16'h0040);
      check({4'h0, taps - t0}, e);
   endtask
   // Enable low must freeze the prescaler
   task t_freeze;
      @(posedge ref_clk) clk_en <= 1'b0;
      #1 t0 = taps;
      repeat (40) @(posedge ref_clk);
      #1 check({4'h0, taps}, {4'h0, t0});
      @(posedge ref_clk) clk_en <= 1'b1;
   endtask
   task t_duty(input [15:0] k, input e);
      @(posedge ref_clk) khz <= k;
      repeat (2) @(posedge ref_clk);
      #1 check(duty, e);
   endtask
   initial begin
      t_ratio(0, 16'h0010);
      t_ratio(1, 16'h0008);
      t_freeze;
      t_duty(16'h1388, 1);
      t_duty(16'h1387, 0);
      final_report;
   end
   // Whole run is near 380 cycles
   initial begin
      #30000 failures = failures + 1;
      final_report;
   end
endmodule
